// ==== design/pbwc_defs.svh ====
// timing constants and widths for the push-button wiper counter
`ifndef PBWC_DEFS_SVH
`define PBWC_DEFS_SVH
`define PBWC_CLK_HZ        125000000
`define PBWC_POS_W         5
`define PBWC_TAPS          32
`define PBWC_POS_MAX       5'h1f
`define PBWC_DEBOUNCE_MS   40
`define PBWC_SLOW_MS       250
`define PBWC_FAST_MS       50
`define PBWC_FAST_AFTER_MS 1000
`define PBWC_RECALL_US     500
`define PBWC_MS_CYC        (`PBWC_CLK_HZ / 1000)
`define PBWC_DEBOUNCE_CYC  (`PBWC_DEBOUNCE_MS * `PBWC_MS_CYC)
`define PBWC_SLOW_CYC      (`PBWC_SLOW_MS * `PBWC_MS_CYC)
`define PBWC_FAST_CYC      (`PBWC_FAST_MS * `PBWC_MS_CYC)
`define PBWC_FAST_AFTER_CYC (`PBWC_FAST_AFTER_MS * `PBWC_MS_CYC)
`define PBWC_RECALL_CYC    (`PBWC_RECALL_US * (`PBWC_CLK_HZ / 1000000))
`endif

// ==== design/pbwc_pkg.sv ====
// types for the push-button wiper counter
package pbwc_pkg;
  typedef enum logic [3:0] {
    PBWC_RECALL = 4'h1,
    PBWC_IDLE   = 4'h2,
    PBWC_SLOW   = 4'h4,
    PBWC_FAST   = 4'h8
  } pbwc_state_type;

  typedef struct packed {
    logic up;
    logic down;
    logic store_en;
  } pbwc_btn_type;

  typedef struct packed {
    logic       wr;
    logic [4:0] data;
  } pbwc_nvm_wr_type;
endpackage

// ==== design/pbwc_debounce.sv ====
// synchroniser plus debounce filter for one active-low pin
`timescale 1ns/1ps
module pbwc_debounce #(
  parameter int unsigned DB_CYC = 5000000
) (
  input  wire logic sys_clk_in,
  input  wire logic rst_n_in,
  input  wire logic pin_n_in,
  output logic      level_n_out
);
  logic        sync1_r;
  logic        sync2_r;
  logic [31:0] cnt_r;

  // two flops before anything reads the pin
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
    end else begin
      sync1_r <= pin_n_in;
      sync2_r <= sync1_r;
    end
  end

  // level must stay different for DB_CYC cycles to be taken
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r       <= 32'h0;
      level_n_out <= 1'b1;
    end else if (sync2_r == level_n_out) begin
      cnt_r <= 32'h0;
    end else if (cnt_r >= DB_CYC - 1) begin
      cnt_r       <= 32'h0;
      level_n_out <= sync2_r;
    end else begin
      cnt_r <= cnt_r + 32'h1;
    end
  end
endmodule

// ==== design/pbwc_top.sv ====
// push-button wiper counter: debounce, scan, saturating counter, tap decode, store
// Overview of operation
// - five-bit wiper counter steps up or down on debounced presses
// - counter decodes to exactly one of thirty-two tap selects
// - counter saturates at both ends, never wraps
// - low pulses shorter than about 40 ms cause no step
// - short press gives one step; held press repeats steps
// - first second of a hold steps at the slow rate
// - after one second of hold, step at the fast rate
// - release stops stepping and returns to standby; next press slow again
// - with store enable low, save counter when supply power-down detected
// - at power-up load counter from nonvolatile memory before stepping
// - store enable high at power-up then low blocks steps until high again
// - with auto store off, each debounced rise of store enable saves once
// - store enable is debounced; low selects auto store, high disables it
// - slow scan steps every 250 ms after debounce
// - fast scan steps every 50 ms
// - recalled position stable within 500 us of power-up
`timescale 1ns/1ps
`include "pbwc_defs.svh"
module pbwc_top #(
  parameter int unsigned DEBOUNCE_CYC  = `PBWC_DEBOUNCE_CYC,
  parameter int unsigned SLOW_CYC      = `PBWC_SLOW_CYC,
  parameter int unsigned FAST_CYC      = `PBWC_FAST_CYC,
  parameter int unsigned FAST_AFTER_CYC = `PBWC_FAST_AFTER_CYC,
  parameter int unsigned RECALL_CYC    = `PBWC_RECALL_CYC
) (
  input  wire logic                  sys_clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  wiper_up_n_in,
  input  wire logic                  wiper_down_n_in,
  input  wire logic                  store_enable_n_in,
  input  wire logic                  power_fail_in,
  input  wire logic [4:0]            nvm_rd_data_in,
  output pbwc_pkg::pbwc_nvm_wr_type  nvm_wr_out,
  output logic [`PBWC_TAPS-1:0]      wiper_tap_output_out,
  output logic [4:0]                 wiper_pos_out,
  output logic                       recall_done_out
);
  pbwc_pkg::pbwc_btn_type   db_n;
  pbwc_pkg::pbwc_state_type state_r;
  logic [31:0] step_cnt_r;
  logic [31:0] hold_cnt_r;
  logic [31:0] recall_cnt_r;
  logic [4:0]  pos_r;
  logic        se_prev_r;
  logic        pf_s1_r;
  logic        pf_s2_r;
  logic        pf_prev_r;
  logic        lock_r;
  logic        locked;
  logic        se_at_pu_r;
  logic        up_req;
  logic        dn_req;
  logic        any_req;
  logic        step;

  // each active-low pin input debounced the same way
  pbwc_debounce #(.DB_CYC(DEBOUNCE_CYC)) u_db_up (
    .sys_clk_in  (sys_clk_in),
    .rst_n_in    (rst_n_in),
    .pin_n_in    (wiper_up_n_in),
    .level_n_out (db_n.up)
  );
  pbwc_debounce #(.DB_CYC(DEBOUNCE_CYC)) u_db_dn (
    .sys_clk_in  (sys_clk_in),
    .rst_n_in    (rst_n_in),
    .pin_n_in    (wiper_down_n_in),
    .level_n_out (db_n.down)
  );
  pbwc_debounce #(.DB_CYC(DEBOUNCE_CYC)) u_db_se (
    .sys_clk_in  (sys_clk_in),
    .rst_n_in    (rst_n_in),
    .pin_n_in    (store_enable_n_in),
    .level_n_out (db_n.store_en)
  );

  // registered lockout alone lags one cycle: a step pressed together
  // with store enable would slip through, so also gate on the live level
  assign locked  = lock_r || (se_at_pu_r && !db_n.store_en);

  // both buttons at once is ambiguous: treat as no request
  assign up_req  = !db_n.up && db_n.down && !locked;
  assign dn_req  = !db_n.down && db_n.up && !locked;
  assign any_req = up_req || dn_req;

  // power-fail detector is an outside level, so synchronise it
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pf_s1_r   <= 1'b0;
      pf_s2_r   <= 1'b0;
      pf_prev_r <= 1'b0;
    end else begin
      pf_s1_r   <= power_fail_in;
      pf_s2_r   <= pf_s1_r;
      pf_prev_r <= pf_s2_r;
    end
  end

  // scan state machine
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r    <= pbwc_pkg::PBWC_RECALL;
      step_cnt_r <= 32'h0;
      hold_cnt_r <= 32'h0;
      recall_cnt_r <= 32'h0;
    end else begin
      case (state_r)
        pbwc_pkg::PBWC_RECALL: begin
          // steps wait for the recall window
          if (recall_cnt_r >= RECALL_CYC - 1) begin
            state_r <= pbwc_pkg::PBWC_IDLE;
          end else begin
            recall_cnt_r <= recall_cnt_r + 32'h1;
          end
        end
        pbwc_pkg::PBWC_IDLE: begin
          step_cnt_r <= 32'h0;
          hold_cnt_r <= 32'h0;
          if (any_req) begin
            state_r <= pbwc_pkg::PBWC_SLOW;
          end
        end
        pbwc_pkg::PBWC_SLOW: begin
          if (!any_req) begin
            state_r <= pbwc_pkg::PBWC_IDLE;
          end else begin
            hold_cnt_r <= hold_cnt_r + 32'h1;
            step_cnt_r <= (step_cnt_r >= SLOW_CYC - 1) ? 32'h0 : step_cnt_r + 32'h1;
            if (hold_cnt_r >= FAST_AFTER_CYC - 1) begin
              state_r    <= pbwc_pkg::PBWC_FAST;
              step_cnt_r <= 32'h0;
            end
          end
        end
        pbwc_pkg::PBWC_FAST: begin
          if (!any_req) begin
            state_r <= pbwc_pkg::PBWC_IDLE;
          end else begin
            step_cnt_r <= (step_cnt_r >= FAST_CYC - 1) ? 32'h0 : step_cnt_r + 32'h1;
          end
        end
        default: begin
          state_r <= pbwc_pkg::PBWC_IDLE;
        end
      endcase
    end
  end

  // first step right after debounce, then one per scan period
  always_comb begin
    case (state_r)
      pbwc_pkg::PBWC_IDLE: step = any_req;
      pbwc_pkg::PBWC_SLOW: step = any_req && (step_cnt_r >= SLOW_CYC - 1)
                                  && (hold_cnt_r < FAST_AFTER_CYC - 1);
      pbwc_pkg::PBWC_FAST: step = any_req && (step_cnt_r >= FAST_CYC - 1);
      default:             step = 1'b0;
    endcase
  end

  // wiper position counter
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pos_r <= 5'h00;
    end else if (state_r == pbwc_pkg::PBWC_RECALL) begin
      pos_r <= nvm_rd_data_in;
    end else if (step && up_req && pos_r != `PBWC_POS_MAX) begin
      pos_r <= pos_r + 5'h01;
    end else if (step && dn_req && pos_r != 5'h00) begin
      pos_r <= pos_r - 5'h01;
    end
  end

  // store enable level captured when recall ends, lockout tracks later lows
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      se_at_pu_r <= 1'b0;
      lock_r     <= 1'b0;
      se_prev_r  <= 1'b1;
    end else begin
      se_prev_r <= db_n.store_en;
      if (state_r == pbwc_pkg::PBWC_RECALL) begin
        se_at_pu_r <= db_n.store_en;
        se_prev_r  <= db_n.store_en;
      end else if (se_at_pu_r) begin
        lock_r <= !db_n.store_en;
      end
    end
  end

  // nonvolatile write request, one cycle pulse
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      nvm_wr_out <= '0;
    end else begin
      nvm_wr_out.data <= pos_r;
      nvm_wr_out.wr   <= 1'b0;
      if (state_r != pbwc_pkg::PBWC_RECALL) begin
        if (!db_n.store_en && pf_s2_r && !pf_prev_r) begin
          nvm_wr_out.wr <= 1'b1;
        end else if (db_n.store_en && !se_prev_r) begin
          nvm_wr_out.wr <= 1'b1;
        end
      end
    end
  end

  // one-hot tap select
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wiper_tap_output_out <= '0;
      wiper_pos_out        <= 5'h00;
      recall_done_out      <= 1'b0;
    end else begin
      wiper_tap_output_out <= `PBWC_TAPS'(1) << pos_r;
      wiper_pos_out        <= pos_r;
      recall_done_out      <= (state_r != pbwc_pkg::PBWC_RECALL);
    end
  end
endmodule

// ==== dv/pbwc_btn_model.sv ====
// push-button and logic-level model for the three active-low pins
`timescale 1ns/1ps
module pbwc_btn_model (
  input  wire logic              up_press_in,
  input  wire logic              dn_press_in,
  input  wire logic              st_press_in,
  output pbwc_pkg::pbwc_btn_type pins_out
);
  // pull-ups hold a released pin high, a press grounds it
  assign pins_out.up       = !up_press_in;
  assign pins_out.down     = !dn_press_in;
  assign pins_out.store_en = !st_press_in;
endmodule

// ==== dv/pbwc_top_sva.sv ====
// port assertions for the wiper counter
`timescale 1ns/1ps
module pbwc_sva #(
  parameter int unsigned FAST_CYC = 8
) (
  input wire logic                 sys_clk_in,
  input wire logic                 rst_n_in,
  input wire logic                 wiper_up_n_in,
  input wire logic                 wiper_down_n_in,
  input wire logic                 store_enable_n_in,
  input wire logic                 power_fail_in,
  input wire pbwc_pkg::pbwc_nvm_wr_type nvm_wr_out,
  input wire logic [31:0]          wiper_tap_output_out,
  input wire logic [4:0]           wiper_pos_out,
  input wire logic                 recall_done_out
);
  logic [31:0] gap_r;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // saturating gap counter: a fast step may never come sooner than FAST_CYC
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) gap_r <= 32'h0;
    else if ($changed(wiper_pos_out)) gap_r <= 32'h0;
    else if (gap_r != 32'hffffffff) gap_r <= gap_r + 32'h1;
  end
  sequence s_run; recall_done_out && $past(recall_done_out); endsequence
  sequence s_idle; (wiper_up_n_in && wiper_down_n_in)[*8]; endsequence
  property p_tap;
    recall_done_out |-> wiper_tap_output_out == (32'h1 << wiper_pos_out);
  endproperty
  property p_step;
    s_run ##0 $changed(wiper_pos_out) |->
      (wiper_pos_out - $past(wiper_pos_out)) inside {5'h01, 5'h1f};
  endproperty
  property p_no_wrap;
    s_run |-> !($past(wiper_pos_out) == 5'h1f && wiper_pos_out == 5'h00)
      && !($past(wiper_pos_out) == 5'h00 && wiper_pos_out == 5'h1f);
  endproperty
  property p_idle; s_idle ##1 s_run |=> $stable(wiper_pos_out); endproperty
  property p_wr_pulse; nvm_wr_out.wr |=> !nvm_wr_out.wr; endproperty
  property p_wr_data; nvm_wr_out.wr |-> nvm_wr_out.data == wiper_pos_out; endproperty
  property p_wr_cause;
    nvm_wr_out.wr |-> $past(store_enable_n_in, 3) || $past(power_fail_in, 3);
  endproperty
  property p_gap; s_run ##0 $changed(wiper_pos_out) |-> gap_r >= FAST_CYC - 1; endproperty
  a_tap: assert property (p_tap) else $error("tap select not one-hot of position");
  a_step: assert property (p_step) else $error("position moved by more than one");
  a_no_wrap: assert property (p_no_wrap) else $error("position wrapped around");
  a_idle: assert property (p_idle) else $error("step while inputs released");
  a_wr_pulse: assert property (p_wr_pulse) else $error("store strobe too long");
  a_wr_data: assert property (p_wr_data) else $error("stored value not position");
  a_wr_cause: assert property (p_wr_cause) else $error("store without cause");
  a_gap: assert property (p_gap) else $error("steps closer than fast period");
endmodule
bind pbwc_top pbwc_sva #(.FAST_CYC(FAST_CYC)) sva_u (.sys_clk_in(sys_clk_in),
  .rst_n_in(rst_n_in), .wiper_up_n_in(wiper_up_n_in), .wiper_down_n_in(wiper_down_n_in),
  .store_enable_n_in(store_enable_n_in), .power_fail_in(power_fail_in),
  .nvm_wr_out(nvm_wr_out), .wiper_tap_output_out(wiper_tap_output_out),
  .wiper_pos_out(wiper_pos_out), .recall_done_out(recall_done_out));

// ==== dv/pbwc_top_tb.sv ====
// self-checking bench for the push-button wiper counter
`timescale 1ns/1ps
module pbwc_top_tb;
  localparam int SLW = 20;
  localparam int FST = 8;
  logic                      sys_clk_in, rst_n_in, up_c, dn_c, st_c, st_lvl, power_fail_in;
  logic [4:0]                nvm_rd_data_in, pos, r, wr_data;
  logic [31:0]               tap;
  logic                      rdone;
  pbwc_pkg::pbwc_btn_type    pins;
  pbwc_pkg::pbwc_nvm_wr_type nvm_wr;
  int                        error_cnt, n_checks, cyc, wr_cnt, n;
  int                        t_q[$];
  pbwc_btn_model btn_u (.up_press_in(up_c), .dn_press_in(dn_c), .st_press_in(st_c),
    .pins_out(pins));
  pbwc_top #(.DEBOUNCE_CYC(4), .SLOW_CYC(SLW), .FAST_CYC(FST), .FAST_AFTER_CYC(60),
    .RECALL_CYC(12)) dut_u (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .wiper_up_n_in(pins.up), .wiper_down_n_in(pins.down),
    .store_enable_n_in(pins.store_en), .power_fail_in(power_fail_in),
    .nvm_rd_data_in(nvm_rd_data_in), .nvm_wr_out(nvm_wr), .wiper_tap_output_out(tap),
    .wiper_pos_out(pos), .recall_done_out(rdone));
  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cyc++;
    if (nvm_wr.wr === 1'b1) begin
      wr_cnt++;
      wr_data = nvm_wr.data;
    end
  end
  always @(pos) if (rdone === 1'b1) t_q.push_back(cyc);
  function automatic logic [4:0] sat(logic [4:0] p, int d);
    if (d > 0) return (p == 5'h1f) ? p : p + 5'h01;
    return (p == 5'h00) ? p : p - 5'h01;
  endfunction
  task chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task cyc_w(int k);
    repeat (k) @(negedge sys_clk_in);
  endtask
  // press for k cycles, then release and let debounce settle
  task press(logic u, logic d, logic s, int k);
    t_q.delete();
    up_c = u; dn_c = d; st_c = s;
    cyc_w(k);
    up_c = 1'b0; dn_c = 1'b0; st_c = st_lvl;
    cyc_w(20);
  endtask
  task boot(logic [4:0] v, logic auto_st);
    rst_n_in = 1'b0; nvm_rd_data_in = v; st_lvl = auto_st; st_c = auto_st;
    cyc_w(2);
    rst_n_in = 1'b1;
    for (int i = 0; i < 100 && rdone !== 1'b1; i++) cyc_w(1);
    cyc_w(10);
    chk("recall", pos, v);
    chk("tap", tap, 32'h1 << v);
    wr_cnt = 0;
  endtask
  task test_done;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    rst_n_in = 1'b0; up_c = 1'b0; dn_c = 1'b0; st_c = 1'b0; st_lvl = 1'b0;
    power_fail_in = 1'b0; nvm_rd_data_in = 5'h00;
    void'($urandom(92256));
    r = 5'($urandom_range(25, 2));
    boot(r, 1'b0);
    press(1'b1, 1'b0, 1'b0, 2);
    chk("short pulse", pos, r);
    press(1'b1, 1'b0, 1'b0, 10);
    r = sat(r, 1);
    chk("single step", pos, r);
    press(1'b1, 1'b1, 1'b0, 30);
    chk("both pressed", pos, r);
    press(1'b1, 1'b0, 1'b0, 400);
    chk("top saturate", pos, 5'h1f);
    n = t_q.size();
    chk("slow period", t_q[1] - t_q[0], SLW);
    chk("fast period", t_q[n-1] - t_q[n-2], FST);
    press(1'b0, 1'b1, 1'b0, 35);
    chk("restart slow", t_q.size(), 2);
    chk("slow again", pos, sat(sat(5'h1f, -1), -1));
    // store held low blocks steps, its release stores once
    press(1'b1, 1'b0, 1'b1, 30);
    chk("locked", pos, 5'h1d);
    chk("manual count", wr_cnt, 1);
    chk("manual data", wr_data, 5'h1d);
    press(1'b0, 1'b1, 1'b0, 400);
    chk("bottom saturate", pos, 5'h00);
    r = 5'($urandom_range(31, 1));
    boot(r, 1'b1);
    press(1'b0, 1'b1, 1'b1, 10);
    r = sat(r, -1);
    chk("auto mode step", pos, r);
    power_fail_in = 1'b1;
    cyc_w(10);
    power_fail_in = 1'b0;
    chk("auto count", wr_cnt, 1);
    chk("auto data", wr_data, r);
    test_done();
  end
  initial begin
    #(8 * 5000);
    error_cnt++;
    test_done();
  end
endmodule
